// *** logic/hfap_pkg.sv ***
// shared offsets, field layouts and types for the host queue port block
package hfap_pkg;
	localparam int DATA_W = 32; // host word width
	localparam int ADDR_W = 8;  // host byte address width
	localparam int NQ     = 4;  // number of queues

	// queue indices, also the bit positions in the flush register
	localparam int Q_RXS = 0; // receive status
	localparam int Q_RXD = 1; // receive data
	localparam int Q_TXS = 2; // transmit status
	localparam int Q_TXD = 3; // transmit data

	// aliased data windows: 16 words, 64 bytes, decoded on bits 7:6
	localparam int ALIAS_LSB = 6;
	localparam logic [7:0] OFF_RXD_BASE = 8'h00;
	localparam logic [7:0] OFF_TXD_BASE = 8'h40;

	// single-word ports and registers
	localparam logic [7:0] OFF_RXS_POP  = 8'h80;
	localparam logic [7:0] OFF_RXS_PEEK = 8'h84;
	localparam logic [7:0] OFF_TXS_POP  = 8'h88;
	localparam logic [7:0] OFF_TXS_PEEK = 8'h8c;
	localparam logic [7:0] OFF_ID       = 8'h90;
	localparam logic [7:0] OFF_CFG      = 8'h94;
	localparam logic [7:0] OFF_CTRL     = 8'h98;
	localparam logic [7:0] OFF_STS      = 8'h9c;
	localparam logic [7:0] OFF_FLUSH    = 8'ha0;

	// capacity register: three 8-bit fields, zero means full depth
	localparam int CFG_CAP_W   = 8;
	localparam int CFG_RXD_LSB = 0;
	localparam int CFG_RXS_LSB = 8;
	localparam int CFG_TXD_LSB = 16;
	localparam int CFG_W       = 24;
	localparam logic [23:0] CFG_RST = 24'h000000;

	// control register
	localparam int CTRL_SRST_BIT = 0;  // self-clearing soft reset
	localparam int CTRL_TXEN_BIT = 8;  // soft_reset_immune drain enable
	localparam logic CTRL_TXEN_RST = 1'b1;

	// status register bits
	localparam int STS_OVR_BIT = 0; // write_one_to_clear overrun
	localparam int STS_UDR_BIT = 1; // clear-on-read underrun
	localparam int STS_FLT_BIT = 2; // latch_high_clear_on_read fault
	localparam int STS_LNK_BIT = 3; // latch_low_clear_on_read link
	localparam int STS_W = 4;
	localparam logic [3:0] STS_RST = 4'h0;

	// decoded target of a host access
	typedef enum logic [3:0] {
		SEL_NONE     = 4'h0,
		SEL_RXD      = 4'h1,
		SEL_TXD      = 4'h2,
		SEL_RXS_POP  = 4'h3,
		SEL_RXS_PEEK = 4'h4,
		SEL_TXS_POP  = 4'h5,
		SEL_TXS_PEEK = 4'h6,
		SEL_ID       = 4'h7,
		SEL_CFG      = 4'h8,
		SEL_CTRL     = 4'h9,
		SEL_STS      = 4'ha,
		SEL_FLUSH    = 4'hb
	} hfap_sel_t;
endpackage

// *** logic/hfap_ram.sv ***
// small queue memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module hfap_ram #(
	parameter int DW = 32, // word width
	parameter int AW = 6   // address width
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [1<<AW]; // storage, no reset needed

	// write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read port, data one edge after the address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= {DW{1'b0}};
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule
`default_nettype wire

// *** logic/hfap_status_bits.sv ***
// status bits with clear-by-write, clear-on-read and latching behaviour
`timescale 1ns/1ps
`default_nettype none
module hfap_status_bits (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       srst,    // soft reset pulse
	input  wire logic       ovr_set, // overrun event
	input  wire logic       ovr_clr, // host wrote one to overrun
	input  wire logic       udr_set, // underrun event
	input  wire logic       rd_clr,  // host read of this register
	input  wire logic       flt_in,  // fault level from core
	input  wire logic       lnk_in,  // link level from core
	output logic      [3:0] sts
);
	logic [3:0] sts_r;   // held bits
	logic [3:0] sts_nxt; // next bits

	// next values; a set beats a host clear in the same cycle, soft reset beats both
	always_comb begin
		sts_nxt = sts_r;
		if (srst) begin
			sts_nxt = hfap_pkg::STS_RST; // defaults
		end else begin
			// zero written leaves it alone
			sts_nxt[hfap_pkg::STS_OVR_BIT] = ovr_set |
				(sts_r[hfap_pkg::STS_OVR_BIT] & ~ovr_clr);
			sts_nxt[hfap_pkg::STS_UDR_BIT] = udr_set |
				(sts_r[hfap_pkg::STS_UDR_BIT] & ~rd_clr);
			sts_nxt[hfap_pkg::STS_FLT_BIT] = flt_in |
				(sts_r[hfap_pkg::STS_FLT_BIT] & ~rd_clr);
			// low latch: read reloads the live level
			sts_nxt[hfap_pkg::STS_LNK_BIT] = rd_clr ? lnk_in :
				(sts_r[hfap_pkg::STS_LNK_BIT] & lnk_in);
		end
	end

	// registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sts_r <= hfap_pkg::STS_RST;
		end else begin
			sts_r <= sts_nxt;
		end
	end

	assign sts = sts_r;
endmodule
`default_nettype wire

// *** logic/hfap_top.sv ***
// host queue ports and register access semantics
// Functional notes
// - writes to read-only registers are ignored
// - write-only registers always read zero
// - writing one clears bit, zero ignored
// - clear-on-read bit cleared by host read
// - latched bits hold until register read
// - immune bits survive soft reset
// - system reset loads all register defaults, soft reset all but the immune bits
// - four queues: rx/tx status and data
// - three queue capacities set by register
// - receive queues ignore host writes
// - rx status pop returns and removes head
// - rx status peek returns head only
// - rx data read returns and removes head
// - rx data aliased over sixteen words
// - tx status pop returns and removes head
// - tx status peek returns head only
// - each tx data write pushes one word unless the queue is full
// - tx data aliased over sixteen words
`timescale 1ns/1ps
`default_nettype none
module hfap_top #(
	parameter int          QAW      = 6,           // log2 queue depth
	parameter logic [31:0] ID_VALUE = 32'h0a5a0001 // arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        host_rd,
	input  wire logic        host_wr,
	input  wire logic [7:0]  host_addr,
	input  wire logic [31:0] host_wdata,
	output logic      [31:0] host_rdata,
	output logic             host_rvalid,
	input  wire logic        rxs_in_valid,
	input  wire logic [31:0] rxs_in_data,
	output logic             rxs_in_ready,
	input  wire logic        rxd_in_valid,
	input  wire logic [31:0] rxd_in_data,
	output logic             rxd_in_ready,
	input  wire logic        txs_in_valid,
	input  wire logic [31:0] txs_in_data,
	output logic             txs_in_ready,
	output logic             txd_out_valid,
	output logic      [31:0] txd_out_data,
	input  wire logic        txd_out_ready,
	input  wire logic        fault_evt,
	input  wire logic        link_ok
);
	localparam int DEPTH = 1 << QAW; // entries per queue
	localparam int CW    = QAW + 1;  // count width
	localparam int NQ    = hfap_pkg::NQ;

	// map a byte address onto its target
	function automatic hfap_pkg::hfap_sel_t f_decode(
		input logic [7:0] a
	);
		logic [7:0] w;
		w = {a[7:2], 2'b00};
		if (w[7:hfap_pkg::ALIAS_LSB] ==
			hfap_pkg::OFF_RXD_BASE[7:hfap_pkg::ALIAS_LSB]) begin
			return hfap_pkg::SEL_RXD;
		end
		if (w[7:hfap_pkg::ALIAS_LSB] ==
			hfap_pkg::OFF_TXD_BASE[7:hfap_pkg::ALIAS_LSB]) begin
			return hfap_pkg::SEL_TXD;
		end
		unique case (w)
			hfap_pkg::OFF_RXS_POP:  return hfap_pkg::SEL_RXS_POP;
			hfap_pkg::OFF_RXS_PEEK: return hfap_pkg::SEL_RXS_PEEK;
			hfap_pkg::OFF_TXS_POP:  return hfap_pkg::SEL_TXS_POP;
			hfap_pkg::OFF_TXS_PEEK: return hfap_pkg::SEL_TXS_PEEK;
			hfap_pkg::OFF_ID:       return hfap_pkg::SEL_ID;
			hfap_pkg::OFF_CFG:      return hfap_pkg::SEL_CFG;
			hfap_pkg::OFF_CTRL:     return hfap_pkg::SEL_CTRL;
			hfap_pkg::OFF_STS:      return hfap_pkg::SEL_STS;
			hfap_pkg::OFF_FLUSH:    return hfap_pkg::SEL_FLUSH;
			default:                return hfap_pkg::SEL_NONE;
		endcase
	endfunction

	// effective capacity; zero or oversize means full depth
	function automatic logic [CW-1:0] f_cap(input logic [7:0] c);
		if (c == 8'h00 || int'(c) > DEPTH) begin
			return CW'(DEPTH);
		end
		return CW'(c);
	endfunction

	// host access decode
	hfap_pkg::hfap_sel_t sel;      // target of this access
	logic                take_rd;  // read accepted
	logic                take_wr;  // write accepted
	// control and configuration state
	logic [23:0] cfg_r;            // capacity fields
	logic [23:0] cfg_nxt;
	logic        srst_r;           // self-clearing soft reset
	logic        srst_nxt;
	logic        txen_r;           // drain enable, immune
	logic        txen_nxt;
	logic [3:0]  sts;              // status bits
	// queue state
	logic [CW-1:0]  cnt_r  [NQ];   // entries held
	logic [CW-1:0]  cnt_nxt[NQ];
	logic [QAW-1:0] wp_r   [NQ];   // write pointers
	logic [QAW-1:0] wp_nxt [NQ];
	logic [QAW-1:0] rp_r   [NQ];   // read pointers
	logic [QAW-1:0] rp_nxt [NQ];
	logic [CW-1:0]  cap    [NQ];   // effective capacities
	logic [31:0]    pdata  [NQ];   // push data
	logic [31:0]    head   [NQ];   // registered head words
	logic [NQ-1:0]  full;
	logic [NQ-1:0]  empty;
	logic [NQ-1:0]  push;
	logic [NQ-1:0]  pop;
	logic [NQ-1:0]  flush;
	logic           fresh_r;       // tx head word is current
	logic           fresh_nxt;
	// read pipeline
	logic           s1_v_r;        // stage one valid
	logic           s1_v_nxt;
	logic           s1_fifo_r;     // answer from a queue head
	logic           s1_fifo_nxt;
	logic [1:0]     s1_q_r;        // which queue
	logic [1:0]     s1_q_nxt;
	logic [31:0]    s1_val_r;      // register value, sampled
	logic [31:0]    s1_val_nxt;
	logic [31:0]    rdata_r;
	logic [31:0]    rdata_nxt;
	logic           rvalid_r;
	logic           rvalid_nxt;

	// accesses are dropped during the soft reset cycle;
	// read wins when both strobes come together
	assign sel     = f_decode(host_addr);
	assign take_rd = host_rd & ~srst_r;
	assign take_wr = host_wr & ~host_rd & ~srst_r;

	// control and configuration next values
	always_comb begin
		cfg_nxt  = cfg_r;
		srst_nxt = 1'b0;   // one cycle only
		txen_nxt = txen_r; // soft reset leaves it alone
		if (srst_r) begin
			cfg_nxt = hfap_pkg::CFG_RST;
		end else if (take_wr && sel == hfap_pkg::SEL_CFG) begin
			// upper bits are not stored
			cfg_nxt = host_wdata[hfap_pkg::CFG_W-1:0];
		end
		if (take_wr && sel == hfap_pkg::SEL_CTRL) begin
			srst_nxt = host_wdata[hfap_pkg::CTRL_SRST_BIT];
			txen_nxt = host_wdata[hfap_pkg::CTRL_TXEN_BIT];
		end
		// identity register has no write path
	end

	// control and configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_r  <= hfap_pkg::CFG_RST;
			srst_r <= 1'b0;
			txen_r <= hfap_pkg::CTRL_TXEN_RST; // system reset only
		end else begin
			cfg_r  <= cfg_nxt;
			srst_r <= srst_nxt;
			txen_r <= txen_nxt;
		end
	end

	// capacities from the register; tx status keeps full depth
	assign cap[hfap_pkg::Q_RXD] = f_cap(
		cfg_r[hfap_pkg::CFG_RXD_LSB +: hfap_pkg::CFG_CAP_W]);
	assign cap[hfap_pkg::Q_RXS] = f_cap(
		cfg_r[hfap_pkg::CFG_RXS_LSB +: hfap_pkg::CFG_CAP_W]);
	assign cap[hfap_pkg::Q_TXD] = f_cap(
		cfg_r[hfap_pkg::CFG_TXD_LSB +: hfap_pkg::CFG_CAP_W]);
	assign cap[hfap_pkg::Q_TXS] = CW'(DEPTH);

	// fullness against the configured capacity
	always_comb begin
		for (int q = 0; q < NQ; q++) begin
			full[q]  = (cnt_r[q] >= cap[q]);
			empty[q] = (cnt_r[q] == {CW{1'b0}});
			flush[q] = srst_r | (take_wr &&
				sel == hfap_pkg::SEL_FLUSH && host_wdata[q]);
		end
	end

	// core side fill ports; held off during soft reset
	assign rxs_in_ready = ~full[hfap_pkg::Q_RXS] & ~srst_r;
	assign rxd_in_ready = ~full[hfap_pkg::Q_RXD] & ~srst_r;
	assign txs_in_ready = ~full[hfap_pkg::Q_TXS] & ~srst_r;

	// push sources: core for three queues, host for tx data;
	// host writes to the receive ports reach no push
	assign push[hfap_pkg::Q_RXS] = rxs_in_valid & rxs_in_ready;
	assign push[hfap_pkg::Q_RXD] = rxd_in_valid & rxd_in_ready;
	assign push[hfap_pkg::Q_TXS] = txs_in_valid & txs_in_ready;
	assign push[hfap_pkg::Q_TXD] = take_wr &&
		sel == hfap_pkg::SEL_TXD && !full[hfap_pkg::Q_TXD];
	assign pdata[hfap_pkg::Q_RXS] = rxs_in_data;
	assign pdata[hfap_pkg::Q_RXD] = rxd_in_data;
	assign pdata[hfap_pkg::Q_TXS] = txs_in_data;
	assign pdata[hfap_pkg::Q_TXD] = host_wdata;

	// pop sources: the pop ports, rx data reads and the tx drain handshake remove, peeks do not
	assign pop[hfap_pkg::Q_RXS] = take_rd &&
		sel == hfap_pkg::SEL_RXS_POP && !empty[hfap_pkg::Q_RXS];
	assign pop[hfap_pkg::Q_RXD] = take_rd &&
		sel == hfap_pkg::SEL_RXD && !empty[hfap_pkg::Q_RXD];
	assign pop[hfap_pkg::Q_TXS] = take_rd &&
		sel == hfap_pkg::SEL_TXS_POP && !empty[hfap_pkg::Q_TXS];
	assign pop[hfap_pkg::Q_TXD] = txd_out_valid & txd_out_ready;

	// pointer and count next values for all four queues
	always_comb begin
		for (int q = 0; q < NQ; q++) begin
			cnt_nxt[q] = cnt_r[q];
			wp_nxt[q]  = wp_r[q];
			rp_nxt[q]  = rp_r[q];
			if (flush[q]) begin
				// also covers soft reset
				cnt_nxt[q] = {CW{1'b0}};
				wp_nxt[q]  = {QAW{1'b0}};
				rp_nxt[q]  = {QAW{1'b0}};
			end else begin
				if (push[q]) begin
					wp_nxt[q] = wp_r[q] + QAW'(1);
				end
				if (pop[q]) begin
					rp_nxt[q] = rp_r[q] + QAW'(1);
				end
				cnt_nxt[q] = cnt_r[q] + CW'(push[q]) - CW'(pop[q]);
			end
		end
	end

	// pointer and count registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int q = 0; q < NQ; q++) begin
				cnt_r[q] <= {CW{1'b0}};
				wp_r[q]  <= {QAW{1'b0}};
				rp_r[q]  <= {QAW{1'b0}};
			end
		end else begin
			for (int q = 0; q < NQ; q++) begin
				cnt_r[q] <= cnt_nxt[q];
				wp_r[q]  <= wp_nxt[q];
				rp_r[q]  <= rp_nxt[q];
			end
		end
	end

	// one memory per queue; head word follows the read pointer
	for (genvar g = 0; g < NQ; g++) begin : g_q
		hfap_ram #(
			.DW (32),
			.AW (QAW)
		) u_ram (
			.clk   (clk),
			.rst   (rst),
			.we    (push[g]),
			.waddr (wp_r[g]),
			.wdata (pdata[g]),
			.raddr (rp_r[g]),
			.rdata (head[g])
		);
	end

	// head word lags a pop by one edge, so the drain side
	// waits one cycle after each word; half rate, no bypass
	always_comb begin
		fresh_nxt = !empty[hfap_pkg::Q_TXD] &&
			!pop[hfap_pkg::Q_TXD] && !flush[hfap_pkg::Q_TXD];
	end

	// head freshness register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fresh_r <= 1'b0;
		end else begin
			fresh_r <= fresh_nxt;
		end
	end

	// drain port, gated by the immune enable bit
	assign txd_out_valid = fresh_r & txen_r;
	assign txd_out_data  = head[hfap_pkg::Q_TXD];

	// a pop-port read that found its queue empty; a plain net, so
	// it follows every signal it reads
	logic udr_evt;
	assign udr_evt = take_rd && (
		(sel == hfap_pkg::SEL_RXD && empty[hfap_pkg::Q_RXD]) ||
		(sel == hfap_pkg::SEL_RXS_POP && empty[hfap_pkg::Q_RXS]) ||
		(sel == hfap_pkg::SEL_TXS_POP && empty[hfap_pkg::Q_TXS]));

	// status bits: overrun on full tx write, underrun on empty pop
	hfap_status_bits u_sts (
		.clk     (clk),
		.rst     (rst),
		.srst    (srst_r),
		.ovr_set (take_wr && sel == hfap_pkg::SEL_TXD &&
			full[hfap_pkg::Q_TXD]),
		.ovr_clr (take_wr && sel == hfap_pkg::SEL_STS &&
			host_wdata[hfap_pkg::STS_OVR_BIT]),
		.udr_set (udr_evt),
		.rd_clr  (take_rd && sel == hfap_pkg::SEL_STS),
		.flt_in  (fault_evt),
		.lnk_in  (link_ok),
		.sts     (sts)
	);

	// read stage one: sample register values before any clear,
	// the memory captures the head word on the same edge
	always_comb begin
		s1_v_nxt    = take_rd;
		s1_fifo_nxt = 1'b0;
		s1_q_nxt    = 2'h0;
		s1_val_nxt  = 32'h00000000;
		unique case (sel)
			hfap_pkg::SEL_RXD: begin
				s1_fifo_nxt = !empty[hfap_pkg::Q_RXD];
				s1_q_nxt    = 2'(hfap_pkg::Q_RXD);
			end
			hfap_pkg::SEL_RXS_POP, hfap_pkg::SEL_RXS_PEEK: begin
				s1_fifo_nxt = !empty[hfap_pkg::Q_RXS];
				s1_q_nxt    = 2'(hfap_pkg::Q_RXS);
			end
			hfap_pkg::SEL_TXS_POP, hfap_pkg::SEL_TXS_PEEK: begin
				s1_fifo_nxt = !empty[hfap_pkg::Q_TXS];
				s1_q_nxt    = 2'(hfap_pkg::Q_TXS);
			end
			hfap_pkg::SEL_ID: begin
				s1_val_nxt = ID_VALUE;
			end
			hfap_pkg::SEL_CFG: begin
				s1_val_nxt = {8'h00, cfg_r};
			end
			hfap_pkg::SEL_CTRL: begin
				s1_val_nxt[hfap_pkg::CTRL_SRST_BIT] = srst_r;
				s1_val_nxt[hfap_pkg::CTRL_TXEN_BIT] = txen_r;
			end
			hfap_pkg::SEL_STS: begin
				s1_val_nxt = {28'h0000000, sts};
			end
			hfap_pkg::SEL_TXD, hfap_pkg::SEL_FLUSH: begin
				s1_val_nxt = 32'h00000000;
			end
			hfap_pkg::SEL_NONE: begin
				s1_val_nxt = 32'h00000000; // unmapped reads zero
			end
		endcase
	end

	// read stage two: pick head word or sampled value
	always_comb begin
		rvalid_nxt = s1_v_r;
		rdata_nxt  = s1_fifo_r ? head[s1_q_r] : s1_val_r;
	end

	// read pipeline registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_v_r    <= 1'b0;
			s1_fifo_r <= 1'b0;
			s1_q_r    <= 2'h0;
			s1_val_r  <= 32'h00000000;
			rdata_r   <= 32'h00000000;
			rvalid_r  <= 1'b0;
		end else begin
			s1_v_r    <= s1_v_nxt;
			s1_fifo_r <= s1_fifo_nxt;
			s1_q_r    <= s1_q_nxt;
			s1_val_r  <= s1_val_nxt;
			rdata_r   <= rdata_nxt;
			rvalid_r  <= rvalid_nxt;
		end
	end

	// answer port straight from flops
	assign host_rdata  = rdata_r;
	assign host_rvalid = rvalid_r;
endmodule
`default_nettype wire

// *** tb/hfap_asserts.sv ***
// concurrent checks on the host port block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module hfap_asserts #(
	parameter logic [31:0] ID_VALUE = 32'h0a5a0001 // arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        host_rd,
	input  wire logic        host_wr,
	input  wire logic [7:0]  host_addr,
	input  wire logic [31:0] host_wdata,
	input  wire logic [31:0] host_rdata,
	input  wire logic        host_rvalid,
	input  wire logic        rxs_in_ready,
	input  wire logic        rxd_in_ready,
	input  wire logic        txs_in_ready,
	input  wire logic        txd_out_valid,
	input  wire logic [31:0] txd_out_data,
	input  wire logic        txd_out_ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic srst_r;   // soft reset cycle, strobes dropped in it
	logic srst_nxt;
	logic rd_tk;    // read accepted this edge
	logic tk1_r;    // read accepted one edge ago
	logic tk2_r;    // read accepted two edges ago
	logic tk1_nxt;
	logic tk2_nxt;

	// soft reset follows a write of one to the control low bit
	always_comb begin
		rd_tk    = host_rd && !srst_r;
		srst_nxt = host_wr && !host_rd && !srst_r && host_wdata[0]
			&& host_addr[7:2] == hfap_pkg::OFF_CTRL[7:2];
		tk1_nxt  = rd_tk;
		tk2_nxt  = tk1_r;
	end

	// registers only; async clear matches the design reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			srst_r <= 1'b0;
			tk1_r  <= 1'b0;
			tk2_r  <= 1'b0;
		end else begin
			srst_r <= srst_nxt;
			tk1_r  <= tk1_nxt;
			tk2_r  <= tk2_nxt;
		end
	end

	// an accepted read at the given word address
	sequence s_rd(logic [5:0] a);
		rd_tk && host_addr[7:2] == a;
	endsequence

	// an accepted read of a place that must answer zero
	sequence s_rd_zero;
		rd_tk && (host_addr[7:6] == 2'h1
			|| host_addr[7:2] == hfap_pkg::OFF_FLUSH[7:2]);
	endsequence

	chk_rd_latency: assert property (host_rvalid == tk2_r)
		else $error("read answer not two cycles after request");
	chk_id_ro: assert property (s_rd(hfap_pkg::OFF_ID[7:2]) |-> ##2
		host_rdata == ID_VALUE) else $error("id register changed");
	chk_wo_zero: assert property (s_rd_zero |-> ##2 host_rdata == 32'h0)
		else $error("write-only place read nonzero");
	chk_srst_selfclr: assert property (
		s_rd(hfap_pkg::OFF_CTRL[7:2]) |-> ##2 !host_rdata[0])
		else $error("soft reset bit seen set");
	chk_srst_refuse: assert property (srst_r |->
		!rxs_in_ready && !rxd_in_ready && !txs_in_ready)
		else $error("push accepted during soft reset");
	chk_srst_empty: assert property (srst_r |=> !txd_out_valid)
		else $error("tx data left after soft reset");
	chk_drain_gap: assert property (txd_out_valid && txd_out_ready
		|=> !txd_out_valid) else $error("no idle cycle after drain");
	chk_drain_hold: assert property (txd_out_valid && !txd_out_ready
		&& !host_wr && !srst_r |=> txd_out_valid && $stable(txd_out_data))
		else $error("drain word dropped while stalled");
	chk_reset_idle: assert property ($fell(rst) |-> !host_rvalid
		&& !txd_out_valid && rxs_in_ready && rxd_in_ready && txs_in_ready)
		else $error("outputs not idle after reset");
	cover property (srst_r);
endmodule
bind hfap_top hfap_asserts #(.ID_VALUE(ID_VALUE)) chk_u (.clk(clk),
	.rst(rst), .host_rd(host_rd), .host_wr(host_wr),
	.host_addr(host_addr), .host_wdata(host_wdata),
	.host_rdata(host_rdata), .host_rvalid(host_rvalid),
	.rxs_in_ready(rxs_in_ready), .rxd_in_ready(rxd_in_ready),
	.txs_in_ready(txs_in_ready), .txd_out_valid(txd_out_valid),
	.txd_out_data(txd_out_data), .txd_out_ready(txd_out_ready));
`default_nettype wire

// *** tb/hfap_core_model.sv ***
// core-side model draining the transmit data stream
`timescale 1ns/1ps
`default_nettype none
module hfap_core_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        stall,
	input  wire logic        txd_out_valid,
	input  wire logic [31:0] txd_out_data,
	output logic             txd_out_ready
);
	logic [31:0] got [0:63]; // drained words in arrival order
	int          n;          // words drained so far
	logic        ph;         // stall phase

	// a word counts only at an edge where valid and ready both stand
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			n <= 0;
			ph <= 1'b0;
			txd_out_ready <= 1'b0;
		end else begin
			ph <= !ph;
			// slow mode: ready only every other cycle
			txd_out_ready <= stall ? ph : 1'b1;
			if (txd_out_valid && txd_out_ready) begin
				got[n] <= txd_out_data;
				n <= n + 1;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/hfap_top_tb.sv ***
// self-checking bench for the host queue port block
`timescale 1ns/1ps
`default_nettype none
module hfap_top_tb;
	localparam logic [31:0] ID  = 32'h13572468; // arbitrary value
	localparam logic [31:0] ALL = 32'hffffffff; // full compare mask
	logic        clk;
	logic        rst;
	logic        host_rd;
	logic        host_wr;
	logic [7:0]  host_addr;
	logic [31:0] host_wdata;
	logic [31:0] host_rdata;
	logic        host_rvalid;
	logic [2:0]  in_valid;  // rx status, rx data, tx status pushes
	logic [31:0] in_data;   // word offered to the push ports
	logic [2:0]  in_ready;
	logic        txd_out_valid;
	logic [31:0] txd_out_data;
	logic        txd_out_ready;
	logic        fault_evt;
	logic        link_ok;
	logic        stall;     // slows the drain side
	int          err_count;
	int          cmp_count;
	int          cyc;

	hfap_top #(.QAW(6), .ID_VALUE(ID)) dut_u (.clk(clk), .rst(rst),
		.host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata(host_rdata),
		.host_rvalid(host_rvalid), .rxs_in_valid(in_valid[0]),
		.rxs_in_data(in_data), .rxs_in_ready(in_ready[0]),
		.rxd_in_valid(in_valid[1]), .rxd_in_data(in_data),
		.rxd_in_ready(in_ready[1]), .txs_in_valid(in_valid[2]),
		.txs_in_data(in_data), .txs_in_ready(in_ready[2]),
		.txd_out_valid(txd_out_valid), .txd_out_data(txd_out_data),
		.txd_out_ready(txd_out_ready), .fault_evt(fault_evt),
		.link_ok(link_ok));
	hfap_core_model core_u (.clk(clk), .rst(rst), .stall(stall),
		.txd_out_valid(txd_out_valid), .txd_out_data(txd_out_data),
		.txd_out_ready(txd_out_ready));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one write strobe; a gap cycle follows before the next
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		host_wr <= 1'b1;
		host_addr <= a;
		host_wdata <= d;
		@(posedge clk);
		host_wr <= 1'b0;
	endtask

	// read, answer checked one cycle after the accepting edge
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clk);
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge clk);
		host_rd <= 1'b0;
		@(posedge clk);
		#1;
		chk({31'h0, host_rvalid}, 32'h1);
		chk(host_rdata & m, e & m);
	endtask

	// core push held until ready is seen, bounded wait
	task automatic push(input int q, input logic [31:0] d);
		int k;
		@(posedge clk);
		in_valid[q] <= 1'b1;
		in_data <= d;
		#1;
		for (k = 0; k < 20 && in_ready[q] !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		chk({31'h0, in_ready[q]}, 32'h1);
		@(posedge clk);
		in_valid[q] <= 1'b0;
	endtask

	task automatic t_defaults();
		rd(8'h90, ID, ALL);
		wr(8'h90, ALL);
		rd(8'h90, ID, ALL);
		rd(8'h94, 32'h0, ALL);
		rd(8'h98, 32'h100, ALL);
		rd(8'h9c, 32'h0, ALL);
		rd(8'ha0, 32'h0, ALL);
		rd(8'h7c, 32'h0, ALL);
		rd(8'hb0, 32'h0, 32'h0);     // read only, value unused
	endtask

	task automatic t_rx_status();
		push(0, 32'h11110001);
		push(0, 32'h11110002);
		wr(8'h80, 32'h0);
		rd(8'h84, 32'h11110001, ALL);
		rd(8'h84, 32'h11110001, ALL);
		rd(8'h80, 32'h11110001, ALL);
		rd(8'h80, 32'h11110002, ALL);
		rd(8'h80, 32'h0, ALL);
		rd(8'h9c, 32'ha, ALL);
		rd(8'h9c, 32'h8, ALL);
	endtask

	task automatic t_rx_data();
		int i;
		for (i = 0; i < 16; i++)
			push(1, 32'h22000000 + 32'(i));
		wr(8'h00, 32'hdead0000);
		for (i = 0; i < 16; i++)
			rd(8'(i * 4), 32'h22000000 + 32'(i), ALL);
	endtask

	task automatic t_tx_status();
		push(2, 32'h330000a1);
		push(2, 32'h330000a2);
		rd(8'h8c, 32'h330000a1, ALL);
		rd(8'h88, 32'h330000a1, ALL);
		rd(8'h8c, 32'h330000a2, ALL);
		rd(8'h88, 32'h330000a2, ALL);
	endtask

	task automatic t_tx_data();
		int i;
		stall <= 1'b1;
		for (i = 0; i < 16; i++)
			wr(8'h40 + 8'(i * 4), 32'h44000000 + 32'(i));
		for (i = 0; i < 200 && core_u.n < 16; i++)
			@(posedge clk);
		chk(32'(core_u.n), 32'd16);
		for (i = 0; i < 16; i++)
			chk(core_u.got[i], 32'h44000000 + 32'(i));
		stall <= 1'b0;
	endtask

	task automatic t_caps();
		wr(8'h98, 32'h0);            // drain held so the queue fills
		wr(8'h94, 32'h00020001);
		rd(8'h94, 32'h00020001, ALL);
		push(1, 32'h55000000);
		#1;
		chk({31'h0, in_ready[1]}, 32'h0);
		wr(8'h40, 32'h1);
		wr(8'h44, 32'h2);
		wr(8'h48, 32'h3);            // refused, overrun
		wr(8'h9c, 32'h0);
		rd(8'h9c, 32'h9, ALL);
		wr(8'h9c, 32'h1);
		rd(8'h9c, 32'h8, ALL);
		rd(8'h00, 32'h55000000, ALL);
		wr(8'ha0, 32'h8);
		wr(8'h94, 32'h0);
		wr(8'h98, 32'h100);          // other bits written zero
		repeat (6) @(posedge clk);
		chk(32'(core_u.n), 32'd16);
	endtask

	task automatic t_latch();
		@(posedge clk);
		fault_evt <= 1'b1;
		link_ok <= 1'b0;
		@(posedge clk);
		fault_evt <= 1'b0;
		link_ok <= 1'b1;
		rd(8'h9c, 32'h4, ALL);
		rd(8'h9c, 32'h8, ALL);
	endtask

	task automatic t_soft_reset();
		wr(8'h94, 32'h00030003);
		wr(8'h98, 32'h0);
		push(0, 32'h66000000);
		wr(8'h98, 32'h1);
		rd(8'h94, 32'h0, ALL);
		rd(8'h98, 32'h0, ALL);
		rd(8'h84, 32'h0, ALL);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(8'h98, 32'h100, ALL);
	endtask

	task automatic final_report();
		$display("errors %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard, far above the few hundred cycles needed
	initial begin
		cyc = 0;
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc == 5000) begin
				err_count++;
				final_report();
			end
		end
	end

	initial begin
		rst = 1'b1;
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_addr = 8'h00;
		host_wdata = 32'h0;
		in_valid = 3'h0;
		in_data = 32'h0;
		fault_evt = 1'b0;
		link_ok = 1'b1;
		stall = 1'b0;
		err_count = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_defaults();
		t_rx_status();
		t_rx_data();
		t_tx_status();
		t_tx_data();
		t_caps();
		t_latch();
		t_soft_reset();
		final_report();
	end
endmodule
`default_nettype wire
